/* File: logic/ocfr_pkg.sv */
// constants, types and helpers shared by the over-current fault retry control block
package ocfr_pkg;

	// command codes at which the two configuration registers are reached
	localparam logic [7:0] OCFR_CMD_FAST_OC_FAULT_RESPONSE = 8'hCA;
	localparam logic [7:0] OCFR_CMD_FAULT_CONFIG           = 8'hC8;

	// values after reset
	localparam logic [7:0] OCFR_RESPONSE_RST = 8'h00;
	localparam logic [7:0] OCFR_CONFIG_RST   = 8'h00;

	// field positions in the response register
	localparam int OCFR_MODE_LSB  = 6;
	localparam int OCFR_RETRY_LSB = 3;
	localparam int OCFR_DELAY_LSB = 0;
	// current delay unit field in the fault configuration register
	localparam int OCFR_IOUT_UNIT_LSB = 2;

	// response modes and retry codes
	localparam logic [1:0] OCFR_MODE_IGNORE   = 2'h0;
	localparam logic [2:0] OCFR_RETRY_NONE    = 3'h0;
	localparam logic [2:0] OCFR_RETRY_FOREVER = 3'h7;

	// timing: one delay base of 1 ms at a 25 ns clock
	localparam int unsigned OCFR_CLK_PERIOD_NS = 25;
	localparam int unsigned OCFR_MS_TIME_NS    = 1000000;
	localparam int unsigned OCFR_MS_CYCLES     = OCFR_MS_TIME_NS / OCFR_CLK_PERIOD_NS;

	// delay units in ms for unit codes 0 to 3
	localparam logic [15:0] OCFR_UNIT0_MS = 16'h0001;
	localparam logic [15:0] OCFR_UNIT1_MS = 16'h0004;
	localparam logic [15:0] OCFR_UNIT2_MS = 16'h0010;
	localparam logic [15:0] OCFR_UNIT3_MS = 16'h0100;

	// pin synchroniser depth
	localparam int OCFR_SYNC_STAGES = 3;

	typedef enum {
		ST_OFF,
		ST_RUN,
		ST_CC_LIMIT,
		ST_FAST_LIMIT,
		ST_RETRY_OFF,
		ST_ATTEMPT,
		ST_LATCHED
	} ocfr_state_type;

	// delay in ms: one unit times two to the power of the count code
	function automatic logic [15:0] ocfr_delay_ms(input logic [1:0] unit_code, input logic [2:0] count_code);
		logic [15:0] unit_ms;
		unit_ms = OCFR_UNIT0_MS;
		case (unit_code)
			2'h1: unit_ms = OCFR_UNIT1_MS;
			2'h2: unit_ms = OCFR_UNIT2_MS;
			2'h3: unit_ms = OCFR_UNIT3_MS;
			default: unit_ms = OCFR_UNIT0_MS;
		endcase
		return unit_ms << count_code;
	endfunction

endpackage

/* File: logic/ocfr_timer_if.sv */
// interface between the retry controller and its delay timer
`timescale 1ns/1ps
interface ocfr_timer_if;
	logic       start;
	logic [1:0] unit_code;
	logic [2:0] count_code;
	logic       expired;

	modport ctrl  (output start, output unit_code, output count_code, input expired);
	modport timer (input start, input unit_code, input count_code, output expired);
endinterface

/* File: logic/ocfr_delay_timer.sv */
// millisecond delay timer for fault hold and restart spacing
`timescale 1ns/1ps
module ocfr_delay_timer
	import ocfr_pkg::*;
#(
	parameter int unsigned MS_CYCLES = ocfr_pkg::OCFR_MS_CYCLES
) (
	input  wire logic    sys_clk,
	input  wire logic    rstn,
	ocfr_timer_if.timer  tif
);
	import ocfr_pkg::*;

	logic [31:0] div_r;
	logic [15:0] ms_r;
	logic [15:0] target_r;
	logic        run_r;
	logic        expired_r;
	logic        ms_tick;

	assign ms_tick     = run_r && (div_r == MS_CYCLES - 1);
	assign tif.expired = expired_r;

	// a start always restarts the count, so restart spacing runs from attempt start
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			div_r     <= 32'h0;
			ms_r      <= 16'h0;
			target_r  <= 16'h1;
			run_r     <= 1'b0;
			expired_r <= 1'b0;
		end else begin
			expired_r <= 1'b0;
			if (tif.start) begin
				// the first ms runs one cycle short to make up for the registered expiry,
				// so attempt starts stay exactly one programmed delay apart
				div_r    <= (MS_CYCLES > 1) ? 32'h1 : 32'h0; // see R7
				ms_r     <= 16'h0;
				target_r <= ocfr_delay_ms(tif.unit_code, tif.count_code); // see R8 see R9
				run_r    <= 1'b1;
			end else if (run_r) begin
				div_r <= ms_tick ? 32'h0 : div_r + 32'h1;
				if (ms_tick) begin
					ms_r <= ms_r + 16'h1;
					if (ms_r + 16'h1 == target_r) begin
						run_r     <= 1'b0;
						expired_r <= 1'b1; // see R7
					end
				end
			end
		end
	end

	// the count of whole ms at expiry matches the programmed delay
	property p_expire_count;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(expired_r) |-> (ms_r == target_r);
	endproperty
	a_expire_count: assert property (p_expire_count) else $error("timer expired at wrong ms count"); // see R7

	// the target equals unit times two to the count code
	property p_target;
		@(posedge sys_clk) disable iff (!rstn)
		tif.start |=> (target_r == ocfr_delay_ms($past(tif.unit_code), $past(tif.count_code)));
	endproperty
	a_target: assert property (p_target) else $error("delay target wrong"); // see R8

	c_expire: cover property (@(posedge sys_clk) disable iff (!rstn) expired_r);
endmodule

/* File: logic/ocfr_retry_ctrl.sv */
// over-current fault response and restart control with its two configuration registers
// Operation
// R1: on a fast over-current fault set the status bit and alert the host.
// R2: mode 00 keeps running, limiting current at the ordinary threshold indefinitely.
// R3: mode 11 limits at fast threshold for the delay, then applies retry setting.
// R4: retry field gives restart attempts; 000 none, 111 without limit.
// R5: retry field zero: no restart, output stays off until fault cleared.
// R6: codes 001-011 allow one to three attempts, then output off until cleared.
// R7: attempt start to next attempt start equals delay count times delay unit.
// R8: delay count n means two to the n units, 1 to 128.
// R9: current delay unit code selects 1, 4, 16 or 256 ms.
// R10: attempt counter resets on fault clear or output commanded off.
`timescale 1ns/1ps
module ocfr_retry_ctrl
	import ocfr_pkg::*;
#(
	parameter int unsigned MS_CYCLES = ocfr_pkg::OCFR_MS_CYCLES
) (
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       fast_oc_fault,
	input  wire logic       output_on,
	input  wire logic       clear_faults,
	input  wire logic       cmd_wr_stb,
	input  wire logic       cmd_rd_stb,
	input  wire logic [7:0] cmd_code,
	input  wire logic [7:0] cmd_wdata,
	output logic      [7:0] cmd_rdata_r,
	output logic            output_enable_r,
	output logic            limit_fast_r,
	output logic            limit_normal_r,
	output logic            fault_status_r,
	output logic            alert_n_r,
	output logic      [2:0] attempt_count_r
);
	import ocfr_pkg::*;

	logic [7:0]     response_r;
	logic [7:0]     config_r;
	logic [2:0]     fault_q_r;
	logic [2:0]     on_q_r;
	logic           fault_s_r;
	logic           fault_d_r;
	logic           on_s_r;
	ocfr_state_type state_r;
	ocfr_state_type state_nxt;
	logic           tmr_start;
	logic           attempt_inc;
	logic           exhausted;
	logic           fault_rise;
	logic           status_nxt;
	logic [1:0]     mode;
	logic [2:0]     retries;

	ocfr_timer_if tif ();

	assign mode           = response_r[OCFR_MODE_LSB +: 2];
	assign retries        = response_r[OCFR_RETRY_LSB +: 3];
	assign tif.start      = tmr_start;
	assign tif.count_code = response_r[OCFR_DELAY_LSB +: 3];
	assign tif.unit_code  = config_r[OCFR_IOUT_UNIT_LSB +: 2];

	ocfr_delay_timer #(
		.MS_CYCLES (MS_CYCLES)
	) u_timer (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.tif     (tif.timer)
	);

	// pin inputs: three stages, a change counts once stages two and three agree
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fault_q_r <= 3'h0;
			on_q_r    <= 3'h0;
			fault_s_r <= 1'b0;
			on_s_r    <= 1'b0;
			fault_d_r <= 1'b0;
		end else begin
			fault_q_r <= {fault_q_r[1:0], fast_oc_fault};
			on_q_r    <= {on_q_r[1:0], output_on};
			if (fault_q_r[1] == fault_q_r[2]) begin
				fault_s_r <= fault_q_r[2];
			end
			if (on_q_r[1] == on_q_r[2]) begin
				on_s_r <= on_q_r[2];
			end
			fault_d_r <= fault_s_r;
		end
	end

	// register writes by command code; unknown codes are ignored
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			response_r <= OCFR_RESPONSE_RST;
			config_r   <= OCFR_CONFIG_RST;
		end else if (cmd_wr_stb) begin
			if (cmd_code == OCFR_CMD_FAST_OC_FAULT_RESPONSE) begin
				response_r <= cmd_wdata;
			end else if (cmd_code == OCFR_CMD_FAULT_CONFIG) begin
				config_r <= cmd_wdata;
			end
		end
	end

	// register reads answer one cycle after the strobe; unmapped codes read zero
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cmd_rdata_r <= 8'h00;
		end else if (cmd_rd_stb) begin
			if (cmd_code == OCFR_CMD_FAST_OC_FAULT_RESPONSE) begin
				cmd_rdata_r <= response_r;
			end else if (cmd_code == OCFR_CMD_FAULT_CONFIG) begin
				cmd_rdata_r <= config_r;
			end else begin
				cmd_rdata_r <= 8'h00;
			end
		end
	end

	// retries used up; code 111 never runs out
	assign exhausted = (retries == OCFR_RETRY_NONE) ||
		((retries != OCFR_RETRY_FOREVER) && (attempt_count_r >= retries)); // see R4 see R5 see R6

	// response state machine; off command overrides everything
	always_comb begin
		state_nxt   = state_r;
		tmr_start   = 1'b0;
		attempt_inc = 1'b0;
		if (!on_s_r) begin
			state_nxt = ST_OFF;
		end else begin
			case (state_r)
				ST_OFF: begin
					state_nxt = ST_RUN;
				end
				ST_RUN: begin
					if (fault_s_r) begin
						if (mode == OCFR_MODE_IGNORE) begin
							state_nxt = ST_CC_LIMIT; // see R2
						end else begin
							state_nxt = ST_FAST_LIMIT; // see R3
							tmr_start = 1'b1;
						end
					end
				end
				ST_CC_LIMIT: begin
					if (!fault_s_r) begin
						state_nxt = ST_RUN;
					end
				end
				ST_FAST_LIMIT: begin
					if (!fault_s_r) begin
						state_nxt = ST_RUN;
					end else if (tif.expired) begin
						if (exhausted) begin
							state_nxt = ST_LATCHED; // see R5
						end else begin
							state_nxt = ST_RETRY_OFF; // see R3
							tmr_start = 1'b1;
						end
					end
				end
				ST_RETRY_OFF: begin
					if (tif.expired) begin
						if (exhausted) begin
							state_nxt = ST_LATCHED; // see R6
						end else begin
							state_nxt   = ST_ATTEMPT;
							tmr_start   = 1'b1; // see R7
							attempt_inc = 1'b1;
						end
					end
				end
				ST_ATTEMPT: begin
					// timer keeps running so the next attempt is spaced from this start
					if (fault_s_r) begin
						state_nxt = ST_RETRY_OFF; // see R7
					end else if (tif.expired) begin
						state_nxt = ST_RUN;
					end
				end
				ST_LATCHED: begin
					if (clear_faults) begin
						state_nxt = ST_RUN; // see R5 see R6
					end
				end
				default: begin
					state_nxt = ST_OFF;
				end
			endcase
		end
	end

	// state and output drive, all registered from the next state
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_r         <= ST_OFF;
			output_enable_r <= 1'b0;
			limit_fast_r    <= 1'b0;
			limit_normal_r  <= 1'b0;
		end else begin
			state_r         <= state_nxt;
			output_enable_r <= (state_nxt == ST_RUN) || (state_nxt == ST_CC_LIMIT) ||
				(state_nxt == ST_FAST_LIMIT) || (state_nxt == ST_ATTEMPT);
			limit_fast_r    <= (state_nxt == ST_FAST_LIMIT); // see R3
			limit_normal_r  <= (state_nxt == ST_CC_LIMIT); // see R2
		end
	end

	// attempt counter; a clear or an off command starts a fresh sequence
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			attempt_count_r <= 3'h0;
		end else if (clear_faults || !on_s_r) begin
			attempt_count_r <= 3'h0; // see R10
		end else if (attempt_inc && attempt_count_r != 3'h7) begin
			attempt_count_r <= attempt_count_r + 3'h1; // see R4
		end
	end

	// sticky fault bit; a new fault wins over a clear in the same cycle
	assign fault_rise = fault_s_r && !fault_d_r;
	assign status_nxt = fault_rise || (fault_status_r && !clear_faults);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fault_status_r <= 1'b0;
			alert_n_r      <= 1'b1;
		end else begin
			fault_status_r <= status_nxt; // see R1
			alert_n_r      <= !status_nxt; // see R1
		end
	end

	property p_status_set;
		@(posedge sys_clk) disable iff (!rstn)
		fault_rise |=> fault_status_r && !alert_n_r;
	endproperty
	a_status_set: assert property (p_status_set) else $error("fault did not set status and alert"); // see R1

	property p_alert_tracks;
		@(posedge sys_clk) disable iff (!rstn)
		alert_n_r == !fault_status_r;
	endproperty
	a_alert_tracks: assert property (p_alert_tracks) else $error("alert differs from status"); // see R1

	property p_cc_mode;
		@(posedge sys_clk) disable iff (!rstn)
		(state_r == ST_RUN && on_s_r && fault_s_r && mode == OCFR_MODE_IGNORE) |=> limit_normal_r && output_enable_r;
	endproperty
	a_cc_mode: assert property (p_cc_mode) else $error("ignore mode did not limit at normal threshold"); // see R2

	property p_fast_mode;
		@(posedge sys_clk) disable iff (!rstn)
		(state_r == ST_RUN && on_s_r && fault_s_r && mode != OCFR_MODE_IGNORE) |=> limit_fast_r ##1 !tif.expired;
	endproperty
	a_fast_mode: assert property (p_fast_mode) else $error("shutdown mode did not start fast limiting"); // see R3

	property p_no_retry;
		@(posedge sys_clk) disable iff (!rstn)
		(state_r == ST_FAST_LIMIT && on_s_r && fault_s_r && tif.expired && retries == OCFR_RETRY_NONE)
			|=> (state_r == ST_LATCHED) && !output_enable_r;
	endproperty
	a_no_retry: assert property (p_no_retry) else $error("zero retries did not latch off"); // see R5

	property p_latched_off;
		@(posedge sys_clk) disable iff (!rstn)
		(state_r == ST_LATCHED) |-> !output_enable_r;
	endproperty
	a_latched_off: assert property (p_latched_off) else $error("output on while latched off"); // see R6

	property p_attempt_limit;
		@(posedge sys_clk) disable iff (!rstn)
		(retries != OCFR_RETRY_FOREVER && $stable(retries) && $rose(state_r == ST_ATTEMPT))
			|-> attempt_count_r <= retries;
	endproperty
	a_attempt_limit: assert property (p_attempt_limit) else $error("too many restart attempts"); // see R6

	property p_counter_reset;
		@(posedge sys_clk) disable iff (!rstn)
		(clear_faults || !on_s_r) |=> attempt_count_r == 3'h0;
	endproperty
	a_counter_reset: assert property (p_counter_reset) else $error("attempt counter not reset"); // see R10

	c_cc_limit: cover property (@(posedge sys_clk) disable iff (!rstn) state_r == ST_CC_LIMIT);
	c_attempt:  cover property (@(posedge sys_clk) disable iff (!rstn) state_r == ST_ATTEMPT);
	c_latched:  cover property (@(posedge sys_clk) disable iff (!rstn) state_r == ST_LATCHED);
endmodule

/* File: verification/ocfr_host_model.sv */
// host side model that reaches the two configuration registers
`timescale 1ns/1ps
module ocfr_host_model (
	input  wire logic       sys_clk,
	output logic            cmd_wr_stb,
	output logic            cmd_rd_stb,
	output logic      [7:0] cmd_code,
	output logic      [7:0] cmd_wdata,
	input  wire logic [7:0] cmd_rdata_r
);
	// idle values
	initial begin
		cmd_wr_stb = 1'b0;
		cmd_rd_stb = 1'b0;
		cmd_code   = 8'h00;
		cmd_wdata  = 8'h00;
	end

	// one byte write, held for exactly the taking edge
	task automatic wr(input logic [7:0] code, input logic [7:0] data);
		@(posedge sys_clk);
		#2;
		cmd_wr_stb = 1'b1;
		cmd_code   = code;
		cmd_wdata  = data;
		@(posedge sys_clk);
		#2;
		cmd_wr_stb = 1'b0;
		cmd_code   = ~code; // stale code is inverted so it never looks live
		cmd_wdata  = ~data;
	endtask

	// one byte read, data taken once the strobe edge has landed
	task automatic rd(input logic [7:0] code, output logic [7:0] data);
		@(posedge sys_clk);
		#2;
		cmd_rd_stb = 1'b1;
		cmd_code   = code;
		@(posedge sys_clk);
		#2;
		cmd_rd_stb = 1'b0;
		cmd_code   = ~code;
		data       = cmd_rdata_r;
	endtask
endmodule

/* File: verification/ocfr_retry_ctrl_tb.sv */
// self-checking bench for the over-current fault retry controller
`timescale 1ns/1ps
module ocfr_retry_ctrl_tb;
	import ocfr_pkg::*;

	localparam int unsigned MSC = 10;

	logic        sys_clk, rstn, fast_oc_fault, output_on, clear_faults;
	logic        cmd_wr_stb, cmd_rd_stb, oe, limit_fast_r, limit_normal_r, fault_status_r, alert_n_r;
	logic  [7:0] cmd_code, cmd_wdata, cmd_rdata_r, rd_v;
	logic  [2:0] attempt_count_r;
	logic [15:0] seed;
	int          fail_count, check_count, i;

	ocfr_retry_ctrl #(.MS_CYCLES(MSC)) i_dut (
		.sys_clk, .rstn, .fast_oc_fault, .output_on, .clear_faults, .cmd_wr_stb, .cmd_rd_stb,
		.cmd_code, .cmd_wdata, .cmd_rdata_r, .output_enable_r(oe), .limit_fast_r, .limit_normal_r,
		.fault_status_r, .alert_n_r, .attempt_count_r);

	ocfr_host_model i_host (.sys_clk, .cmd_wr_stb, .cmd_rd_stb, .cmd_code, .cmd_wdata, .cmd_rdata_r);

	// clock
	always #12.5 sys_clk = ~sys_clk;

	// watchdog, far beyond the longest expected run
	initial begin
		#(25 * 90000);
		fail_count++;
		finish_test();
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// expected delay in clock cycles for a unit code and a count code
	function automatic int dly(input int u, input int c);
		int ms;
		ms = (u == 3) ? 256 : (1 << (2 * u));
		return (ms << c) * MSC;
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask

	// bounded wait for the output enable to reach a level, counting edges
	task automatic wait_en(input logic v, output int n);
		n = 0;
		while (oe !== v && n < 40000) begin
			cyc(1);
			n++;
		end
		if (n >= 40000) check(16'h0, 16'h1);
	endtask

	task automatic pulse_clear;
		clear_faults = 1'b1;
		cyc(1);
		clear_faults = 1'b0;
	endtask

	// shutdown and restart sequence with a fault held until the attempts are used up, or through eight attempts for code 111
	task automatic run_retry(input int u, input int c, input logic [2:0] r);
		int d, n, n0, k;
		d = dly(u, c);
		i_host.wr(OCFR_CMD_FAULT_CONFIG, 8'(u << OCFR_IOUT_UNIT_LSB));
		// retry code 010 runs in mode 01, which the controller treats as 11
		i_host.wr(OCFR_CMD_FAST_OC_FAULT_RESPONSE, {(r == 3'h2) ? 2'h1 : 2'h3, r, 3'(c)});
		wait_en(1'b1, n);
		fast_oc_fault = 1'b1;
		cyc(7);
		check(limit_fast_r, 1'b1);
		check(fault_status_r, 1'b1);
		wait_en(1'b0, n);
		check(n + 7 >= d && n + 7 <= d + 6, 1'b1);
		for (k = 0; k < ((r == 3'h7) ? 8 : r); k++) begin
			wait_en(1'b0, n0);
			wait_en(1'b1, n);
			check(16'(n0 + n), 16'(d));
		end
		cyc(2 * d + 10);
		if (r != 3'h7) check(oe, 1'b0);
		check(attempt_count_r, r);
		// the fault going away alone must not bring a latched output back
		fast_oc_fault = 1'b0;
		cyc(10);
		if (r != 3'h7) check(oe, 1'b0);
		// an off command starts a fresh sequence while attempts are still counted
		if (r == 3'h7) begin
			output_on = 1'b0;
			cyc(10);
			check(attempt_count_r, 3'h0);
			output_on = 1'b1;
			cyc(10);
		end
		pulse_clear();
		cyc(2);
		check(attempt_count_r, 3'h0);
		check(oe, 1'b1);
		check(alert_n_r, 1'b1);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		sys_clk = 1'b0;
		rstn = 1'b0;
		fast_oc_fault = 1'b0;
		output_on = 1'b0;
		clear_faults = 1'b0;
		seed = 16'h0001;
		fail_count = 0;
		check_count = 0;
		cyc(3);
		rstn = 1'b1;
		check({oe, alert_n_r, fault_status_r, attempt_count_r}, 6'h10);
		// register round trips with random data, plus an unmapped code
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			i_host.wr(OCFR_CMD_FAST_OC_FAULT_RESPONSE, seed[7:0]);
			i_host.wr(OCFR_CMD_FAULT_CONFIG, seed[15:8]);
			i_host.rd(OCFR_CMD_FAST_OC_FAULT_RESPONSE, rd_v);
			check(rd_v, seed[7:0]);
			i_host.rd(OCFR_CMD_FAULT_CONFIG, rd_v);
			check(rd_v[3:2], seed[11:10]);
			i_host.rd(8'hCB, rd_v);
			check(rd_v, 8'h00);
		end
		// mode 00 keeps the output on and limits at the ordinary threshold
		output_on = 1'b1;
		i_host.wr(OCFR_CMD_FAULT_CONFIG, 8'h00);
		i_host.wr(OCFR_CMD_FAST_OC_FAULT_RESPONSE, {OCFR_MODE_IGNORE, seed[5:0]});
		fast_oc_fault = 1'b1;
		cyc(8);
		check({fault_status_r, alert_n_r}, 2'h2);
		cyc(300);
		check({oe, limit_normal_r, limit_fast_r}, 3'h6);
		fast_oc_fault = 1'b0;
		cyc(8);
		check(fault_status_r, 1'b1);
		pulse_clear();
		cyc(2);
		check(alert_n_r, 1'b1);
		// retry codes, units and random delay counts
		run_retry(0, 0, OCFR_RETRY_NONE);
		seed = lfsr(seed);
		run_retry(1, seed[1:0], 3'h1);
		run_retry(0, 7, 3'h2);
		seed = lfsr(seed);
		run_retry(2, seed[1:0], 3'h3);
		run_retry(3, 0, 3'h1);
		run_retry(0, 0, OCFR_RETRY_FOREVER);
		finish_test();
	end
endmodule
